// ==== mpas_pkg.sv ====
// Constants and types for the motor PWM and converter trigger sequencer
package mpas_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int DEADTIME_NS = 500;
    localparam int PRETRIG_NS = 250;
    localparam logic [15:0] DEADTIME_CYC = 16'((DEADTIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] PRETRIG_CYC = 16'((PRETRIG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] SLOW_PRESCALE = 4'hf;
    localparam logic [2:0] FILTER_SAMPLES = 3'h4;
    localparam logic [15:0] DLY_CNT_MAX = 16'hffff;

    // ==========================================================
    // Reset values
    localparam logic [15:0] CNT_INIT_RST = 16'hf448;
    localparam logic [15:0] PERIOD_TOP_RST = 16'h0bb7;
    localparam logic [15:0] DLY_POINT_RST = 16'h2328;
    localparam logic [15:0] SLOW_WRAP_RST = 16'h0ea5;
    localparam logic [15:0] DUTY_RST = 16'h0000;
    localparam logic [7:0] MASK_RST = 8'hc0;
    localparam logic [5:0] CMP_REF_RST = 6'h3e;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CNT_INIT = 8'h04;
    localparam logic [7:0] A_PERIOD_TOP = 8'h08;
    localparam logic [7:0] A_DEADTIME = 8'h0c;
    localparam logic [7:0] A_PRETRIG = 8'h10;
    localparam logic [7:0] A_DLY_POINT = 8'h14;
    localparam logic [7:0] A_DUTY0 = 8'h18;
    localparam logic [7:0] A_DUTY1 = 8'h1c;
    localparam logic [7:0] A_DUTY2 = 8'h20;
    localparam logic [7:0] A_MASK = 8'h24;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam logic [7:0] A_SLOW_WRAP = 8'h2c;
    localparam logic [7:0] A_CMP_REF = 8'h30;
    localparam logic [7:0] A_CONV_CFG = 8'h34;

    // ==========================================================
    // Types
    typedef struct packed {
        logic back_to_back;
        logic ls_act_low;
        logic hs_act_low;
        logic fault_act_low;
        logic fault_from_cmp;
        logic seqerr_ie;
        logic delay_ie;
        logic trig_en;
        logic pwm_en;
    } mpas_ctrl_type;

    localparam mpas_ctrl_type CTRL_RST = 9'h10e;

    typedef struct packed {
        logic clk_6mhz;
        logic continuous;
        logic avg32;
    } mpas_conv_cfg_type;

    localparam mpas_conv_cfg_type CONV_NORM = 3'h0;
    localparam mpas_conv_cfg_type CONV_CAL = 3'h7;

endpackage

// ==== mpas_top.sv ====
// Three-phase PWM generator with converter trigger sequencer
// Behaviour
// - Each PWM counter reload emits the reload trigger, which restarts the delay counter.
// - First pre-trigger on each channel fires a programmed half dead time after trigger.
// - Back-to-back mode fires second pre-trigger right after first conversion completes.
// - Fast-loop interrupt pulses when the first conversion completes.
// - Disabled reload trigger leaves the delay counter running; software toggles it.
// - Delay flag sets when the delay counter reaches the delay interrupt point.
// - Sequence error flags when a pre-trigger repeats before its result was read.
// - Delay and sequence errors share one request line; error flag tells which.
// - Delay interrupt point length sets PWM to control rate ratio, default one and a half.
// - Only six channels are driven; the remaining two are held low whatever the mask.
// - Channels pair as 0-1, 2-3, 4-5 with complementary outputs.
// - Fault disables outputs; they return at first reload after fault clears.
// - Period is count from initial value to top value, defaults -3000 and 2999.
// - Each pair inserts a programmable dead time between its edges.
// - Reload trigger is issued when the counter loads its initial value.
// - Fault source is pin or comparator, polarity selectable.
// - High-side and low-side output polarity are separately configurable.
// - Comparator reference is six bits at 62; filter needs four matching samples.
// - Delay counter runs on the same clock as the PWM counter.
// - Slow timer runs at clock over sixteen, counts to wrap, ticks when it wraps to zero, not at PWM reload.
// - Calibration selects 6 MHz, continuous, 32-sample averaging; writing bit 0 low restores defaults.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module mpas_top (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Pins
    input wire logic fault_pin,
    input wire logic cmp_in,
    output logic [7:0] pwm_out,
    output logic [5:0] cmp_ref,
    // Converters
    input wire logic [1:0] conv_done,
    input wire logic [3:0] result_read,
    output logic [1:0] pretrig0,
    output logic [1:0] pretrig1,
    output mpas_pkg::mpas_conv_cfg_type conv_cfg,
    // Events
    output logic reload_trigger_out,
    output logic fast_irq,
    output logic seq_irq,
    output logic slow_irq
);

    // ==========================================================
    // Registers
    mpas_pkg::mpas_ctrl_type ctrl;
    logic [15:0] cnt_init;
    logic [15:0] period_top;
    logic [15:0] deadtime;
    logic [15:0] pretrig_dly;
    logic [15:0] dly_point;
    logic [15:0] duty [3];
    logic [7:0] chan_mask;
    logic [15:0] slow_wrap;
    logic dflag;
    logic eflag;
    logic wr_ce;
    logic [1:0] stat_clr;
    always_comb begin
        wr_ce = wr & ce;
        stat_clr = (wr_ce && addr == mpas_pkg::A_STATUS) ? wdata[1:0] : 2'h0;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= mpas_pkg::CTRL_RST;
            cnt_init <= mpas_pkg::CNT_INIT_RST;
            period_top <= mpas_pkg::PERIOD_TOP_RST;
            deadtime <= mpas_pkg::DEADTIME_CYC;
            pretrig_dly <= mpas_pkg::PRETRIG_CYC;
            dly_point <= mpas_pkg::DLY_POINT_RST;
            duty[0] <= mpas_pkg::DUTY_RST;
            duty[1] <= mpas_pkg::DUTY_RST;
            duty[2] <= mpas_pkg::DUTY_RST;
            chan_mask <= mpas_pkg::MASK_RST;
            slow_wrap <= mpas_pkg::SLOW_WRAP_RST;
            cmp_ref <= mpas_pkg::CMP_REF_RST;
            conv_cfg <= mpas_pkg::CONV_NORM;
        end else if (wr_ce) begin
            unique case (addr)
                mpas_pkg::A_CTRL: ctrl <= wdata[8:0];
                mpas_pkg::A_CNT_INIT: cnt_init <= wdata[15:0];
                mpas_pkg::A_PERIOD_TOP: period_top <= wdata[15:0];
                mpas_pkg::A_DEADTIME: deadtime <= wdata[15:0];
                mpas_pkg::A_PRETRIG: pretrig_dly <= wdata[15:0];
                mpas_pkg::A_DLY_POINT: dly_point <= wdata[15:0];
                mpas_pkg::A_DUTY0: duty[0] <= wdata[15:0];
                mpas_pkg::A_DUTY1: duty[1] <= wdata[15:0];
                mpas_pkg::A_DUTY2: duty[2] <= wdata[15:0];
                mpas_pkg::A_MASK: chan_mask <= wdata[7:0];
                mpas_pkg::A_SLOW_WRAP: slow_wrap <= wdata[15:0];
                mpas_pkg::A_CMP_REF: cmp_ref <= wdata[5:0];
                mpas_pkg::A_CONV_CFG: conv_cfg <= wdata[0] ? mpas_pkg::CONV_CAL
                                                           : mpas_pkg::CONV_NORM;
                default: ;
            endcase
        end
    end
    // ==========================================================
    // Pin synchronisers and comparator filter
    logic [1:0] fault_sync;
    logic [1:0] cmp_sync;
    logic cmp_filt;
    logic [2:0] filt_cnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_sync <= 2'h0;
            cmp_sync <= 2'h0;
        end else if (ce) begin
            fault_sync <= {fault_sync[0], fault_pin};
            cmp_sync <= {cmp_sync[0], cmp_in};
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmp_filt <= 1'b0;
            filt_cnt <= 3'h0;
        end else if (ce) begin
            if (cmp_sync[1] == cmp_filt) begin
                filt_cnt <= 3'h0;
            end else if (filt_cnt == mpas_pkg::FILTER_SAMPLES - 3'h1) begin
                cmp_filt <= cmp_sync[1];
                filt_cnt <= 3'h0;
            end else begin
                filt_cnt <= filt_cnt + 3'h1;
            end
        end
    end
    // ==========================================================
    // PWM counter and reload trigger
    logic [15:0] pwm_cnt;
    logic wrap;
    logic reload_trig;
    always_comb begin
        wrap = ctrl.pwm_en && pwm_cnt == period_top;
        reload_trig = wrap && ctrl.trig_en;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwm_cnt <= mpas_pkg::CNT_INIT_RST;
        end else if (ce) begin
            if (!ctrl.pwm_en || wrap) begin
                pwm_cnt <= cnt_init;
            end else begin
                pwm_cnt <= pwm_cnt + 16'h1;
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reload_trigger_out <= 1'b0;
        end else if (ce) begin
            reload_trigger_out <= reload_trig;
        end
    end
    // ==========================================================
    // Fault handling
    logic fault_act;
    logic fault_hold;
    always_comb begin
        fault_act = (ctrl.fault_from_cmp ? cmp_filt : fault_sync[1])
                    ^ ctrl.fault_act_low;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_hold <= 1'b0;
        end else if (ce) begin
            if (fault_act) begin
                fault_hold <= 1'b1;
            end else if (wrap) begin
                fault_hold <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Complementary pairs with dead time
    logic [2:0] raw_now;
    logic [2:0] raw_q;
    logic [2:0] hs_on;
    logic [2:0] ls_on;
    logic [15:0] dt_cnt [3];
    for (genvar p = 0; p < 3; p++) begin : g_pair
        always_comb begin
            raw_now[p] = $signed(pwm_cnt) < $signed(duty[p]);
            hs_on[p] = raw_q[p] && raw_now[p] && dt_cnt[p] == 16'h0;
            ls_on[p] = !raw_q[p] && !raw_now[p] && dt_cnt[p] == 16'h0;
        end
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                raw_q[p] <= 1'b0;
                dt_cnt[p] <= 16'h0;
            end else if (ce) begin
                if (raw_now[p] != raw_q[p]) begin
                    raw_q[p] <= raw_now[p];
                    dt_cnt[p] <= (deadtime == 16'h0) ? 16'h0 : deadtime - 16'h1;
                end else if (dt_cnt[p] != 16'h0) begin
                    dt_cnt[p] <= dt_cnt[p] - 16'h1;
                end
            end
        end
    end
    logic gate;
    logic [7:0] next_pwm;
    always_comb begin
        gate = ctrl.pwm_en && !fault_hold && !fault_act;
        next_pwm = 8'h00;
        for (int p = 0; p < 3; p++) begin
            next_pwm[2 * p] = (hs_on[p] && gate && !chan_mask[2 * p])
                              ^ ctrl.hs_act_low;
            next_pwm[2 * p + 1] = (ls_on[p] && gate && !chan_mask[2 * p + 1])
                                  ^ ctrl.ls_act_low;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwm_out <= 8'h00;
        end else if (ce) begin
            pwm_out <= next_pwm;
        end
    end
    // ==========================================================
    // Delay counter and pre-triggers
    logic [15:0] dly_cnt;
    logic dly_run;
    logic hit_pre;
    logic hit_point;
    logic [1:0] wait_second;
    logic [1:0] first_done;
    logic [1:0] fire1;
    logic [3:0] fire;
    logic [3:0] pending;
    logic seq_err;
    always_comb begin
        hit_pre = dly_run && dly_cnt == pretrig_dly;
        hit_point = dly_run && dly_cnt == dly_point;
        first_done = conv_done & wait_second;
        fire1 = first_done & {2{ctrl.back_to_back}};
        fire = {fire1[1], hit_pre, fire1[0], hit_pre};
        seq_err = |(fire & pending & ~result_read);
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dly_cnt <= 16'h0;
            dly_run <= 1'b0;
        end else if (ce) begin
            if (reload_trig) begin
                dly_cnt <= 16'h0;
                dly_run <= 1'b1;
            end else if (dly_run) begin
                if (dly_cnt == mpas_pkg::DLY_CNT_MAX) begin
                    dly_run <= 1'b0;
                end else begin
                    dly_cnt <= dly_cnt + 16'h1;
                end
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_second <= 2'h0;
            pending <= 4'h0;
        end else if (ce) begin
            wait_second <= (wait_second & ~conv_done) | {2{hit_pre}};
            pending <= fire | (pending & ~result_read);
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pretrig0 <= 2'h0;
            pretrig1 <= 2'h0;
            fast_irq <= 1'b0;
        end else if (ce) begin
            pretrig0 <= {2{hit_pre}};
            pretrig1 <= fire1;
            fast_irq <= first_done[0];
        end
    end
    // ==========================================================
    // Shared delay and sequence-error request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dflag <= 1'b0;
            eflag <= 1'b0;
            seq_irq <= 1'b0;
        end else if (ce) begin
            dflag <= hit_point | (dflag & ~stat_clr[0]);
            eflag <= seq_err | (eflag & ~stat_clr[1]);
            seq_irq <= (dflag && ctrl.delay_ie) || (eflag && ctrl.seqerr_ie);
        end
    end
    // ==========================================================
    // Slow-loop timer
    logic [3:0] slow_pre;
    logic [15:0] slow_cnt;
    logic slow_wrap_hit;
    always_comb begin
        slow_wrap_hit = slow_pre == mpas_pkg::SLOW_PRESCALE && slow_cnt == slow_wrap;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            slow_pre <= 4'h0;
            slow_cnt <= 16'h0;
            slow_irq <= 1'b0;
        end else if (ce) begin
            slow_pre <= slow_pre + 4'h1;
            slow_irq <= slow_wrap_hit;
            if (slow_pre == mpas_pkg::SLOW_PRESCALE) begin
                slow_cnt <= slow_wrap_hit ? 16'h0 : slow_cnt + 16'h1;
            end
        end
    end
    // ==========================================================
    // Register read port
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (ce) begin
            rdata <= 32'h0;
            if (rd) begin
                unique case (addr)
                    mpas_pkg::A_CTRL: rdata <= {23'h0, ctrl};
                    mpas_pkg::A_CNT_INIT: rdata <= {16'h0, cnt_init};
                    mpas_pkg::A_PERIOD_TOP: rdata <= {16'h0, period_top};
                    mpas_pkg::A_DEADTIME: rdata <= {16'h0, deadtime};
                    mpas_pkg::A_PRETRIG: rdata <= {16'h0, pretrig_dly};
                    mpas_pkg::A_DLY_POINT: rdata <= {16'h0, dly_point};
                    mpas_pkg::A_DUTY0: rdata <= {16'h0, duty[0]};
                    mpas_pkg::A_DUTY1: rdata <= {16'h0, duty[1]};
                    mpas_pkg::A_DUTY2: rdata <= {16'h0, duty[2]};
                    mpas_pkg::A_MASK: rdata <= {24'h0, chan_mask};
                    mpas_pkg::A_STATUS: rdata <= {28'h0, cmp_filt, fault_hold, eflag, dflag};
                    mpas_pkg::A_SLOW_WRAP: rdata <= {16'h0, slow_wrap};
                    mpas_pkg::A_CMP_REF: rdata <= {26'h0, cmp_ref};
                    mpas_pkg::A_CONV_CFG: rdata <= {29'h0, conv_cfg};
                    default: rdata <= 32'h0;
                endcase
            end
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    reload_trig_a: assert property (ce && wrap && ctrl.trig_en |=> reload_trigger_out)
        else $error("reload trigger missing at wrap");
    trig_gated_a: assert property (ce && !reload_trig |=> !reload_trigger_out)
        else $error("reload trigger while disabled");
    dly_restart_a: assert property (ce && reload_trig |=> dly_cnt == 16'h0 && dly_run)
        else $error("delay counter not restarted");
    pretrig_time_a: assert property (ce && reload_trig ##1 (ce && !reload_trig)
        [*3] |-> (dly_cnt == 16'h2))
        else $error("delay counter off count");
    pretrig_fire_a: assert property (ce && hit_pre |=> pretrig0 == 2'h3 ##1 !(|pretrig0))
        else $error("pre-trigger not a single pulse");
    b2b_fire_a: assert property (ce && first_done[0] && ctrl.back_to_back
        |=> pretrig1[0] && fast_irq)
        else $error("second pre-trigger or fast irq missing");
    seq_err_a: assert property (ce && seq_err |=> eflag ##1 (eflag || $past(stat_clr[1])))
        else $error("sequence error not flagged");
    irq_share_a: assert property (ce && $rose(dflag) && ctrl.delay_ie |=> seq_irq)
        else $error("shared request not raised");
    mask_idle_a: assert property (pwm_out[7:6] == 2'h0)
        else $error("unused channels driven");
    pair_excl_a: assert property (!(hs_on[0] && ls_on[0]) && !(hs_on[1] && ls_on[1]))
        else $error("pair overlap");
    fault_off_a: assert property (ce && fault_act |=> (pwm_out[5:0] ^ {3{ctrl.ls_act_low,
        ctrl.hs_act_low}}) == 6'h0 || $changed(ctrl))
        else $error("outputs active during fault");
    slow_tick_a: assert property (ce && slow_wrap_hit |=> slow_irq && slow_cnt == 16'h0)
        else $error("slow tick missing");
    reload_c: cover property (ce && reload_trig ##[1:300] pretrig0[0]);
    fault_c: cover property (fault_hold ##1 !fault_hold);
    seq_err_c: cover property (ce && seq_err);

endmodule

`default_nettype wire

// ==== mpas_conv_model.sv ====
// Behavioural model of the two analog converters behind the sequencer
`timescale 1ns/1ps
`default_nettype none

module mpas_conv_model #(
    parameter int CONV_CYC = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Test control
    input wire logic skip_read,
    // Triggers in
    input wire logic [1:0] pretrig0,
    input wire logic [1:0] pretrig1,
    // Converter events out
    output logic [1:0] conv_done,
    output logic [3:0] result_read
);
    // ==========================================================
    // Conversion timers and result reads
    int cnt [2];
    logic second [2];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= '{0, 0};
            second <= '{1'b0, 1'b0};
            conv_done <= 2'h0;
            result_read <= 4'h0;
        end else begin
            result_read <= 4'h0;
            for (int ch = 0; ch < 2; ch++) begin
                conv_done[ch] <= (cnt[ch] == 1);
                if (conv_done[ch] && !skip_read) begin
                    result_read[2 * ch + int'(second[ch])] <= 1'b1;
                end
                if (pretrig0[ch]) begin
                    cnt[ch] <= CONV_CYC;
                    second[ch] <= 1'b0;
                end else if (pretrig1[ch]) begin
                    cnt[ch] <= CONV_CYC;
                    second[ch] <= 1'b1;
                end else if (cnt[ch] != 0) begin
                    cnt[ch] <= cnt[ch] - 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== test_motor_pwm_adc_sync.sv ====
// Self-checking testbench for the motor PWM and trigger sequencer
`timescale 1ns/1ps
`default_nettype none

module test_motor_pwm_adc_sync;
    // ==========================================================
    // Signals
    logic mclk, rst, ce, wr, rd, fault_pin, cmp_in, skip_read;
    logic [7:0] addr, pwm_out;
    logic [31:0] wdata, rdata, d;
    logic [5:0] cmp_ref;
    logic [1:0] conv_done, pretrig0, pretrig1;
    logic [3:0] result_read;
    mpas_pkg::mpas_conv_cfg_type conv_cfg;
    logic reload_trigger_out, fast_irq, seq_irq, slow_irq;
    wire [4:0] ev;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int both_low = 0;
    int t, tp, bl;
    logic [7:0] ra [10] = '{mpas_pkg::A_CTRL, mpas_pkg::A_PERIOD_TOP, mpas_pkg::A_DEADTIME,
        mpas_pkg::A_PRETRIG, mpas_pkg::A_DLY_POINT, mpas_pkg::A_MASK, mpas_pkg::A_SLOW_WRAP,
        mpas_pkg::A_CMP_REF, mpas_pkg::A_CONV_CFG, 8'h3c};
    logic [31:0] rv [10] = '{32'(mpas_pkg::CTRL_RST), 32'(mpas_pkg::PERIOD_TOP_RST),
        32'(mpas_pkg::DEADTIME_CYC), 32'(mpas_pkg::PRETRIG_CYC), 32'(mpas_pkg::DLY_POINT_RST),
        32'(mpas_pkg::MASK_RST), 32'(mpas_pkg::SLOW_WRAP_RST), 32'(mpas_pkg::CMP_REF_RST),
        32'(mpas_pkg::CONV_NORM), 32'h0};

    assign ev = {seq_irq, slow_irq, fast_irq, pretrig0[0], reload_trigger_out};

    // ==========================================================
    // Design and converter model
    mpas_top i_mpas_top (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .fault_pin(fault_pin), .cmp_in(cmp_in),
        .pwm_out(pwm_out), .cmp_ref(cmp_ref), .conv_done(conv_done),
        .result_read(result_read), .pretrig0(pretrig0), .pretrig1(pretrig1),
        .conv_cfg(conv_cfg), .reload_trigger_out(reload_trigger_out), .fast_irq(fast_irq),
        .seq_irq(seq_irq), .slow_irq(slow_irq));

    mpas_conv_model i_mpas_conv_model (.mclk(mclk), .rst(rst), .skip_read(skip_read),
        .pretrig0(pretrig0), .pretrig1(pretrig1), .conv_done(conv_done),
        .result_read(result_read));

    // ==========================================================
    // Tasks
    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic wait_ev(input int sel);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (ev[sel] !== 1'b1 && n < 2000);
    endtask

    // ==========================================================
    // Clock, cycle count, dead time monitor, timeout
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (pwm_out[1:0] === 2'b00) begin
            both_low <= both_low + 1;
        end
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        fault_pin = 1'b0;
        cmp_in = 1'b0;
        skip_read = 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        check(32'(cmp_ref), 32'h3e);
        for (int i = 0; i < 10; i++) begin
            rd_reg(ra[i], d);
            check(d, rv[i]);
        end
        wr_reg(mpas_pkg::A_SLOW_WRAP, 32'h9);
        wr_reg(mpas_pkg::A_CNT_INIT, 32'hff9c);
        wr_reg(mpas_pkg::A_PERIOD_TOP, 32'h63);
        wr_reg(mpas_pkg::A_DLY_POINT, 32'h12c);
        wr_reg(mpas_pkg::A_CTRL, 32'h10f);
        wait_ev(0);
        wait_ev(0);
        t = cyc;
        bl = both_low;
        wait_ev(1);
        tp = cyc;
        check(cyc - t, 32'(mpas_pkg::PRETRIG_CYC) + 1);
        @(posedge mclk);
        #1;
        check(32'(pretrig0), 32'h0);
        wait_ev(2);
        check(cyc - tp, 32'd7);
        check(32'(pretrig1), 32'h3);
        wait_ev(0);
        check(cyc - t, 32'd200);
        check(both_low - bl, 32'(2 * mpas_pkg::DEADTIME_CYC));
        t = cyc;
        wr_reg(mpas_pkg::A_CTRL, 32'h10d);
        wait_ev(4);
        check(cyc - t, 32'd302);
        rd_reg(mpas_pkg::A_STATUS, d);
        check(d, 32'h1);
        wr_reg(mpas_pkg::A_STATUS, 32'h3);
        wr_reg(mpas_pkg::A_CTRL, 32'h10f);
        wait_ev(0);
        check(cyc - t, 32'd400);
        check(32'(seq_irq), 32'h0);
        skip_read <= 1'b1;
        wait_ev(0);
        wait_ev(0);
        repeat (40) @(posedge mclk);
        rd_reg(mpas_pkg::A_STATUS, d);
        check(d, 32'h2);
        check(32'(seq_irq), 32'h1);
        skip_read <= 1'b0;
        wr_reg(mpas_pkg::A_CTRL, 32'h16f);
        repeat (6) @(posedge mclk);
        #1;
        check(32'(pwm_out), 32'h15);
        rd_reg(mpas_pkg::A_STATUS, d);
        check(d & 32'h4, 32'h4);
        wait_ev(0);
        wr_reg(mpas_pkg::A_CTRL, 32'h14f);
        repeat (5) @(posedge mclk);
        #1;
        check(32'(pwm_out), 32'h15);
        wait_ev(0);
        rd_reg(mpas_pkg::A_STATUS, d);
        check(d & 32'h4, 32'h0);
        wr_reg(mpas_pkg::A_CTRL, 32'h11f);
        cmp_in <= 1'b1;
        rd_reg(mpas_pkg::A_STATUS, d);
        check(d & 32'h8, 32'h0);
        repeat (10) @(posedge mclk);
        rd_reg(mpas_pkg::A_STATUS, d);
        check(d & 32'h8, 32'h8);
        check(32'(pwm_out), 32'h0);
        wait_ev(3);
        t = cyc;
        wait_ev(3);
        check(cyc - t, 32'd160);
        wait_ev(0);
        t = cyc;
        ce <= 1'b0;
        repeat (50) @(posedge mclk);
        ce <= 1'b1;
        wait_ev(0);
        check(cyc - t, 32'd250);
        wr_reg(mpas_pkg::A_CONV_CFG, 32'h1);
        #1;
        check(32'(conv_cfg), 32'(mpas_pkg::CONV_CAL));
        wr_reg(mpas_pkg::A_CONV_CFG, 32'h0);
        #1;
        check(32'(conv_cfg), 32'(mpas_pkg::CONV_NORM));
        report_and_stop();
    end
endmodule
`default_nettype wire
